// [hw/crfi_defines.svh]
// Constants of the core reset and early-initialization block: AXI4-Lite offsets, field positions, reset values.
// Assumes inclusion by bare name from the core module and the testbench.
`ifndef CRFI_DEFINES_SVH
`define CRFI_DEFINES_SVH
// Register byte offsets
`define CRFI_OFF_CTRL 12'h000
`define CRFI_OFF_CS_SEL 12'h004
`define CRFI_OFF_CS_BASE 12'h008
`define CRFI_OFF_IP 12'h00C
`define CRFI_OFF_GDATA 12'h010
`define CRFI_OFF_FETCH 12'h014
`define CRFI_OFF_FPCW 12'h018
`define CRFI_OFF_FPTAG 12'h01C
`define CRFI_OFF_FPSW 12'h020
`define CRFI_OFF_CMD 12'h024
`define CRFI_OFF_INSTR 12'h028
`define CRFI_OFF_RESULT 12'h02C
`define CRFI_OFF_CVALID 12'h030
`define CRFI_OFF_MSR_IDX 12'h034
`define CRFI_OFF_MSR_DAT 12'h038
`define CRFI_OFF_IRQ_STAT 12'h03C
`define CRFI_OFF_IRQ_MASK 12'h040
`define CRFI_OFF_PAGE 12'h044
// Main control register fields
`define CRFI_BIT_MONITOR 1
`define CRFI_BIT_EMULATE 2
`define CRFI_BIT_TASKSW 3
`define CRFI_BIT_ET 4
`define CRFI_BIT_NATIVE 5
`define CRFI_BIT_NOTWT 29
`define CRFI_BIT_CDIS 30
// Page entry cache fields
`define CRFI_BIT_PWT 3
`define CRFI_BIT_PCD 4
// Reset and initialization values
`define CRFI_RST_CS_SEL 16'hF000
`define CRFI_RST_CS_BASE 32'hFFFF0000
`define CRFI_RST_IP 32'h0000FFF0
`define CRFI_RST_CTRL 32'h60000010
`define CRFI_RST_FPCW 16'h0040
`define CRFI_RST_FPSW 16'h0000
`define CRFI_RST_FPTAG 16'h5555
`define CRFI_INIT_FPCW 16'h037F
`define CRFI_INIT_FPTAG 16'hFFFF
// Command bits
`define CRFI_CMD_LOAD_CS 0
`define CRFI_CMD_FP_INIT 1
`define CRFI_CMD_EXEC 2
`define CRFI_CMD_SOFT_INIT 3
// Interrupt status bits
`define CRFI_IRQ_DNA 0
`define CRFI_IRQ_FPERR_INT 1
`define CRFI_IRQ_HANG 2
`define CRFI_IRQ_FETCH 3
`define CRFI_IRQ_W 4
`endif

// [hw/crfi_pkg.sv]
// Types of the core reset and early-initialization block.
// Assumes the defines header sits beside it.
package crfi_pkg;
  typedef enum logic [1:0] {crfi_ins_none, crfi_ins_fp, crfi_ins_wait} crfi_instr_t;
  // Identification word fields
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [7:0] ext_family;
    logic [3:0] ext_model;
    logic [1:0] rsvd_mid;
    logic [1:0] proc_type;
    logic [3:0] family;
    logic [3:0] model;
    logic [3:0] stepping;
  } crfi_ident_t;
  // Outcome of an instruction handed to the block
  typedef struct packed {
    logic dna;
    logic fp_exec;
    logic fp_err_int;
    logic fp_err_ext;
    logic hang;
  } crfi_result_t;
endpackage

// [hw/crfi_core.sv]
// Core reset state, floating-point control flags, cache valid state and model register file.
// Assumes an AXI4-Lite master on aclk and a synchronous active-low reset.
`include "crfi_defines.svh"
module crfi_core #(
  parameter int cache_lines = 16,
  parameter int msr_count = 8,
  parameter logic [3:0] ident_stepping = 4'h1, // Arbitrary value
  parameter logic [3:0] ident_model = 4'h2, // Arbitrary value
  parameter logic [3:0] ident_family = 4'h3, // Arbitrary value
  parameter logic [1:0] ident_type = 2'h1, // Arbitrary value
  parameter logic [3:0] ident_ext_model = 4'h4, // Arbitrary value
  parameter logic [7:0] ident_ext_family = 8'h00 // Arbitrary value
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status towards the rest of the core
  output logic [31:0] fetch_addr,
  output logic fetch_req,
  output logic cache_enable,
  output logic fp_error_ext,
  output logic irq
);
  import crfi_pkg::*;

  logic [31:0] main_control_reg;
  logic [15:0] cs_selector;
  logic [31:0] cs_base;
  logic [31:0] instruction_pointer;
  logic [31:0] general_data_reg;
  logic [15:0] fp_control;
  logic [15:0] fp_status;
  logic [15:0] fp_tag;
  logic [cache_lines-1:0] cache_valid;
  logic [31:0] model_specific_regs [msr_count];
  logic [$clog2(msr_count)-1:0] msr_index;
  logic [1:0] instr_sel;
  logic fp_present;
  logic emu_present;
  logic fp_pending_err;
  crfi_result_t result;
  logic [`CRFI_IRQ_W-1:0] irq_status;
  logic [`CRFI_IRQ_W-1:0] irq_mask;
  logic hung;
  logic rst_d;
  crfi_ident_t ident;
  logic page_cache_disable;
  logic page_write_through;
  logic page_cacheable;

  // Write channel bookkeeping
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] wmask;
  logic cmd_exec, cmd_load_cs, cmd_fp_init, cmd_soft_init;
  logic ev_dna, ev_fperr, ev_hang;
  logic next_dna, next_exec, next_err_int, next_err_ext, next_hang;

  assign ident = '{rsvd_hi: 4'h0, ext_family: ident_ext_family, ext_model: ident_ext_model, rsvd_mid: 2'h0,
                   proc_type: ident_type, family: ident_family, model: ident_model, stepping: ident_stepping};
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign cmd_exec = wr_fire && aw_addr == `CRFI_OFF_CMD && w_strb[0] && w_data[`CRFI_CMD_EXEC];
  assign cmd_load_cs = wr_fire && aw_addr == `CRFI_OFF_CMD && w_strb[0] && w_data[`CRFI_CMD_LOAD_CS];
  assign cmd_fp_init = wr_fire && aw_addr == `CRFI_OFF_CMD && w_strb[0] && w_data[`CRFI_CMD_FP_INIT];
  assign cmd_soft_init = wr_fire && aw_addr == `CRFI_OFF_CMD && w_strb[0] && w_data[`CRFI_CMD_SOFT_INIT];

  // Instruction outcome decode from the current flags
  always_comb begin
    next_dna = 1'b0;
    next_exec = 1'b0;
    next_err_int = 1'b0;
    next_err_ext = 1'b0;
    next_hang = 1'b0;
    case (crfi_instr_t'(instr_sel))
      crfi_ins_fp: begin
        if (main_control_reg[`CRFI_BIT_EMULATE]) begin
          if (!fp_present && !emu_present) begin
            next_hang = 1'b1;
          end else begin
            next_dna = 1'b1;
          end
        end else begin
          next_exec = 1'b1;
          if (fp_pending_err) begin
            next_err_int = main_control_reg[`CRFI_BIT_NATIVE];
            next_err_ext = !main_control_reg[`CRFI_BIT_NATIVE];
          end
        end
      end
      crfi_ins_wait: begin
        // Task-switched only matters with monitor set
        next_dna = main_control_reg[`CRFI_BIT_MONITOR] && main_control_reg[`CRFI_BIT_TASKSW];
      end
      default: begin
        next_dna = 1'b0;
      end
    endcase
  end
  assign ev_dna = cmd_exec && next_dna;
  assign ev_fperr = cmd_exec && next_err_int;
  assign ev_hang = cmd_exec && next_hang;

  // AXI write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `CRFI_OFF_PAGE || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Control flags, segment and pointer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_control_reg <= `CRFI_RST_CTRL;
      cs_selector <= `CRFI_RST_CS_SEL;
      cs_base <= `CRFI_RST_CS_BASE;
      instruction_pointer <= `CRFI_RST_IP;
      instr_sel <= 2'h0;
      fp_present <= 1'b1;
      emu_present <= 1'b0;
      fp_pending_err <= 1'b0;
      msr_index <= '0;
    end else if (wr_fire) begin
      case (aw_addr)
        `CRFI_OFF_CTRL: begin
          main_control_reg <= (main_control_reg & ~wmask) | (w_data & wmask);
        end
        `CRFI_OFF_CS_SEL: begin
          // A new selector gives the real-mode base
          cs_selector <= w_data[15:0];
          cs_base <= {12'h000, w_data[15:0], 4'h0};
        end
        `CRFI_OFF_IP: begin
          instruction_pointer <= (instruction_pointer & ~wmask) | (w_data & wmask);
        end
        `CRFI_OFF_INSTR: begin
          instr_sel <= w_data[1:0];
          fp_present <= w_data[4];
          emu_present <= w_data[5];
          fp_pending_err <= w_data[6];
        end
        `CRFI_OFF_MSR_IDX: begin
          msr_index <= w_data[$clog2(msr_count)-1:0];
        end
        default: begin
          if (cmd_load_cs) begin
            cs_base <= {12'h000, cs_selector, 4'h0};
          end
        end
      endcase
    end
  end

  // Identification word, reloaded by every reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_d <= 1'b0;
      general_data_reg <= 32'h00000000;
    end else begin
      rst_d <= 1'b1;
      if (!rst_d) begin
        general_data_reg <= ident;
      end
    end
  end

  // Floating-point unit state; soft initialization leaves it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_control <= `CRFI_RST_FPCW;
      fp_status <= `CRFI_RST_FPSW;
      fp_tag <= `CRFI_RST_FPTAG;
    end else if (cmd_fp_init) begin
      fp_control <= `CRFI_INIT_FPCW;
      fp_status <= 16'h0000;
      fp_tag <= `CRFI_INIT_FPTAG;
    end else if (cmd_soft_init) begin
      fp_control <= fp_control;
    end
  end

  // Cache line valid bits, all invalid at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cache_valid <= '0;
    end else if (wr_fire && aw_addr == `CRFI_OFF_CVALID) begin
      cache_valid <= cache_valid | w_data[cache_lines-1:0];
    end
  end

  // Model-specific registers, index then data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < msr_count; i++) begin
        model_specific_regs[i] <= 32'h00000000;
      end
    end else if (wr_fire && aw_addr == `CRFI_OFF_MSR_DAT) begin
      model_specific_regs[msr_index] <= w_data;
    end
  end

  // Instruction outcome and hang latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
      hung <= 1'b0;
      fp_error_ext <= 1'b0;
    end else if (cmd_exec) begin
      result <= '{dna: next_dna, fp_exec: next_exec, fp_err_int: next_err_int,
                  fp_err_ext: next_err_ext, hang: next_hang};
      hung <= hung | next_hang;
      fp_error_ext <= next_err_ext;
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_fire && aw_addr == `CRFI_OFF_IRQ_MASK) begin
        irq_mask <= w_data[`CRFI_IRQ_W-1:0];
      end
      irq_status <= (irq_status & ~((wr_fire && aw_addr == `CRFI_OFF_IRQ_STAT) ? w_data[`CRFI_IRQ_W-1:0] : '0))
                    | {!rst_d, ev_hang, ev_fperr, ev_dna};
    end
  end

  // Registered outputs to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_addr <= `CRFI_RST_CS_BASE + `CRFI_RST_IP;
      fetch_req <= 1'b0;
      cache_enable <= 1'b0;
      irq <= 1'b0;
    end else begin
      fetch_addr <= cs_base + instruction_pointer;
      fetch_req <= rst_d && !hung;
      cache_enable <= !main_control_reg[`CRFI_BIT_CDIS] && !main_control_reg[`CRFI_BIT_NOTWT];
      irq <= |(irq_status & irq_mask);
    end
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `CRFI_OFF_CTRL: s_axi_rdata <= main_control_reg;
        `CRFI_OFF_CS_SEL: s_axi_rdata <= {16'h0000, cs_selector};
        `CRFI_OFF_CS_BASE: s_axi_rdata <= cs_base;
        `CRFI_OFF_IP: s_axi_rdata <= instruction_pointer;
        `CRFI_OFF_GDATA: s_axi_rdata <= general_data_reg;
        `CRFI_OFF_FETCH: s_axi_rdata <= cs_base + instruction_pointer;
        `CRFI_OFF_FPCW: s_axi_rdata <= {16'h0000, fp_control};
        `CRFI_OFF_FPTAG: s_axi_rdata <= {16'h0000, fp_tag};
        `CRFI_OFF_FPSW: s_axi_rdata <= {16'h0000, fp_status};
        `CRFI_OFF_CMD: s_axi_rdata <= 32'h00000000;
        `CRFI_OFF_INSTR: s_axi_rdata <= {25'h0, fp_pending_err, emu_present, fp_present, 2'h0, instr_sel};
        `CRFI_OFF_RESULT: s_axi_rdata <= {26'h0, hung, result};
        `CRFI_OFF_CVALID: s_axi_rdata <= 32'(cache_valid);
        `CRFI_OFF_MSR_IDX: s_axi_rdata <= 32'(msr_index);
        `CRFI_OFF_MSR_DAT: s_axi_rdata <= model_specific_regs[msr_index];
        `CRFI_OFF_IRQ_STAT: s_axi_rdata <= 32'(irq_status);
        `CRFI_OFF_IRQ_MASK: s_axi_rdata <= 32'(irq_mask);
        `CRFI_OFF_PAGE: s_axi_rdata <= {27'h0, page_cache_disable, page_write_through, 2'h0, page_cacheable};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Page-level cache attributes of the entry in use
  // Kept apart from the global flags so a page can refuse caching on its own
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_cache_disable <= 1'b0;
      page_write_through <= 1'b0;
    end else if (wr_fire && aw_addr == `CRFI_OFF_PAGE) begin
      page_cache_disable <= w_data[`CRFI_BIT_PCD];
      page_write_through <= w_data[`CRFI_BIT_PWT];
    end
  end

  // A page caches only when global caching is on and its own disable is clear
  assign page_cacheable = !main_control_reg[`CRFI_BIT_CDIS] && !main_control_reg[`CRFI_BIT_NOTWT]
                          && !page_cache_disable;
endmodule // crfi_core

// [testbench/crfi_core_sva.sv]
// Port assertions for the core reset block.
// Assumes a bind to crfi_core, one clock domain.
module crfi_core_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core status
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_req,
  input wire logic cache_enable,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset state at release
  reset_state_a: assert property ($rose(aresetn) |-> !fetch_req && !cache_enable && !irq)
    else $error("outputs not in reset state at release");
  fetch_start_a: assert property ($rose(aresetn) |-> ##[1:3] fetch_req)
    else $error("fetch request late after reset");
  first_fetch_a: assert property ($rose(fetch_req) |-> fetch_addr == 32'hFFFFFFF0)
    else $error("first fetch address wrong");
  // Caching only follows a bus write
  cache_rise_a: assert property ($rose(cache_enable) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
    || $past(s_axi_wvalid, 3))
    else $error("caching enabled without a write");
  // Bus answers
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  one_answer_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  // Main scenarios
  cover property ($rose(cache_enable));
  cover property ($rose(irq));
  cover property ($fell(fetch_req));
endmodule // crfi_core_chk

bind crfi_core crfi_core_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .fetch_addr, .fetch_req, .cache_enable, .irq);

// [testbench/tb.sv]
// Self-checking bench for the core reset block.
// Assumes the package and defines header compiled first.
`include "crfi_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import crfi_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic fetch_req, cache_enable, fp_error_ext, irq;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, fetch_addr, d, v;
  logic [31:0] mv [8];
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, bq, rq, k;
  logic [4:0] f;
  int n_mismatch = 0, n_compared = 0;
  crfi_core #(.ident_stepping(4'h5), .ident_model(4'hA), .ident_family(4'h6), .ident_type(2'h2),
    .ident_ext_model(4'h3)) u_dut ( // Arbitrary identification values
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetch_addr, .fetch_req, .cache_enable,
    .fp_error_ext, .irq);
  always #25 aclk = ~aclk;
  // Expected identification word
  function automatic logic [31:0] exp_id();
    crfi_ident_t x;
    x = '0;
    x.stepping = 4'h5;
    x.model = 4'hA;
    x.family = 4'h6;
    x.proc_type = 2'h2;
    x.ext_model = 4'h3;
    x.ext_family = 8'h00;
    return x;
  endfunction
  // Bus write, handshake judged just before each edge
  task automatic wr(input logic [11:0] a, input logic [31:0] dv);
    logic ta, tw, got;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      got = bvalid;
      bq = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (got) begin
        bready <= 1'h0;
        break;
      end
    end
  endtask
  // Bus read
  task automatic rd(input logic [11:0] a);
    logic ta, got;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(negedge aclk);
      ta = arvalid && arready;
      got = rvalid;
      d = rdata;
      rq = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (got) begin
        rready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  // Run one instruction with given control and instruction words
  task automatic ex(input logic [31:0] c, input logic [31:0] ins);
    wr(`CRFI_OFF_CTRL, c);
    wr(`CRFI_OFF_INSTR, ins);
    wr(`CRFI_OFF_CMD, 32'h4);
    rd(`CRFI_OFF_RESULT);
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    void'($urandom(86));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    settle();
    // Reset state, read before any selector load
    `CHK(fetch_addr, 32'hFFFFFFF0)
    `CHK(cache_enable, 1'h0)
    rc(`CRFI_OFF_CTRL, 32'h60000010);
    rc(`CRFI_OFF_CS_SEL, 32'h0000F000);
    rc(`CRFI_OFF_CS_BASE, 32'hFFFF0000);
    rc(`CRFI_OFF_IP, 32'h0000FFF0);
    rc(`CRFI_OFF_FETCH, 32'hFFFFFFF0);
    rc(`CRFI_OFF_GDATA, exp_id());
    rc(`CRFI_OFF_CVALID, 32'h0);
    rc(`CRFI_OFF_FPTAG, 32'h5555);
    $display("Test reset done");
    // Selector loads, corner values first
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hFFFF : (i == 1) ? 32'h0 : {16'h0, 16'($urandom)};
      wr(`CRFI_OFF_CS_SEL, v);
      rc(`CRFI_OFF_CS_BASE, {v[27:0], 4'h0});
      rc(`CRFI_OFF_FETCH, {v[27:0], 4'h0} + 32'hFFF0);
    end
    $display("Test selector done");
    // Soft init keeps, initialize resets
    wr(`CRFI_OFF_CMD, 32'h8);
    rc(`CRFI_OFF_FPCW, 32'h0040);
    wr(`CRFI_OFF_CMD, 32'h2);
    rc(`CRFI_OFF_FPCW, 32'h037F);
    rc(`CRFI_OFF_FPTAG, 32'hFFFF);
    rc(`CRFI_OFF_FPSW, 32'h0);
    wr(`CRFI_OFF_CMD, 32'h8);
    rc(`CRFI_OFF_FPTAG, 32'hFFFF);
    $display("Test fp init done");
    // Every mix of monitor, emulate, task-switched, native and pending-error flags for both instruction kinds
    for (int i = 0; i < 64; i++) begin
      f = i[4:0];
      k = i[5] ? 2'h2 : 2'h1;
      ex({1'h0, 2'h3, 23'h0, f[1], 1'h1, f[2], f[4], f[3], 1'h0}, {25'h0, f[0], 2'h1, 2'h0, k});
      if (k == 2'h1) `CHK(d[4:0], {f[4], !f[4], !f[4] && f[0] && f[1], !f[4] && f[0] && !f[1], 1'h0})
      else `CHK(d[4], f[3] && f[2])
      `CHK(fp_error_ext, k == 2'h1 && !f[4] && f[0] && !f[1])
    end
    $display("Test flags done");
    // Interrupt clear, mask and raise
    wr(`CRFI_OFF_IRQ_MASK, 32'h0);
    wr(`CRFI_OFF_IRQ_STAT, 32'hF);
    rc(`CRFI_OFF_IRQ_STAT, 32'h0);
    ex(32'h60000014, 32'h11);
    settle();
    `CHK(irq, 1'h0)
    wr(`CRFI_OFF_IRQ_MASK, 32'h1);
    settle();
    `CHK(irq, 1'h1)
    wr(`CRFI_OFF_IRQ_STAT, 32'h1);
    settle();
    `CHK(irq, 1'h0)
    $display("Test irq done");
    // Cache enable needs both flags clear
    wr(`CRFI_OFF_CVALID, 32'hFFFF);
    rc(`CRFI_OFF_CVALID, 32'hFFFF);
    foreach (mv[i]) begin
      v = (i == 0) ? 32'h20000010 : (i == 1) ? 32'h10 : 32'h40000010;
      if (i < 3) wr(`CRFI_OFF_CTRL, v);
      settle();
      if (i < 3) `CHK(cache_enable, i == 1)
    end
    // Page attributes, then a top-byte write that must keep the low flags
    wr(`CRFI_OFF_CTRL, 32'h10);
    wr(`CRFI_OFF_PAGE, 32'h8);
    rc(`CRFI_OFF_PAGE, 32'h9);
    wr(`CRFI_OFF_PAGE, 32'h10);
    rc(`CRFI_OFF_PAGE, 32'h10);
    wstrb <= 4'h8;
    wr(`CRFI_OFF_CTRL, 32'h60000000);
    wstrb <= 4'hF;
    rc(`CRFI_OFF_CTRL, 32'h60000010);
    // Model registers, unmapped places
    foreach (mv[i]) begin
      mv[i] = $urandom;
      wr(`CRFI_OFF_MSR_IDX, i);
      wr(`CRFI_OFF_MSR_DAT, mv[i]);
    end
    foreach (mv[i]) begin
      wr(`CRFI_OFF_MSR_IDX, i);
      rc(`CRFI_OFF_MSR_DAT, mv[i]);
    end
    rc(12'h0FC, 32'h0);
    `CHK(rq, 2'h2)
    wr(12'h0FC, 32'h1);
    `CHK(bq, 2'h2)
    $display("Test cache and model regs done");
    // Hang, then reset in mid-run
    ex(32'h60000014, 32'h1);
    `CHK(d[0], 1'h1)
    settle();
    `CHK(fetch_req, 1'h0)
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    settle();
    `CHK(fetch_req, 1'h1)
    `CHK(fetch_addr, 32'hFFFFFFF0)
    rc(`CRFI_OFF_CTRL, 32'h60000010);
    rc(`CRFI_OFF_CS_BASE, 32'hFFFF0000);
    wr(`CRFI_OFF_CMD, 32'h1);
    rc(`CRFI_OFF_CS_BASE, 32'h000F0000);
    $display("Test hang done");
    final_report();
  end
endmodule // tb
